// ### rtl/srg_top.sv
/*
  srg_top: bit-rate configuration, serial clock generation and receive
  status flags of a byte-wide serial controller, behind an APB slave.
  assumes: the shift logic sits on the same clock, pulses XFER_DONE for
  one cycle with RX_DATA valid, and holds XFER_ACTIVE during a transfer.
*/
// Implementation choice: the APB interface to the registers.
// Overview of operation
// - prescaler divides clock by select plus one
// - divider gives two to power code plus one
// - rate register accessible at any time
// - rate register top bit reads zero
// - rate applies when acting as clock master
// - status register ignores writes except match clear
// - status low four bits read zero
// - receive full set on transfer completion
// - status read then data read clears full
// - match set after full when byte matches
// - status read then write one clears match
// - match interrupt while flag and enable set
`timescale 1ns/1ps
`default_nettype none
module srg_top
  import srg_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RSTN,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [SRG_ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // shift logic side
  input wire logic XFER_ACTIVE,
  input wire logic XFER_DONE,
  input wire logic [7:0] RX_DATA,
  // serial clock
  output logic SCK,
  output logic SCK_EDGE,
  // interrupt
  output logic IRQ
);

  // ***********************************************
  // state
  // ***********************************************
  srg_regs_t r_q;
  srg_regs_t r_d;
  srg_rate_if rif ();

  // ***********************************************
  // decode helpers
  // ***********************************************
  // word index of a byte address, low two bits ignored
  function automatic logic hit(input logic [SRG_ADDR_W-1:0] addr,
                               input logic [7:0] idx);
    logic [SRG_ADDR_W-1:0] word;
    word = {2'b00, addr[SRG_ADDR_W-1:2]};
    hit = (word == idx);
  endfunction

  function automatic logic mapped(input logic [SRG_ADDR_W-1:0] addr);
    mapped = hit(addr, SRG_IDX_CTRL) |
             hit(addr, SRG_IDX_RATE) |
             hit(addr, SRG_IDX_STAT) |
             hit(addr, SRG_IDX_MATCH) |
             hit(addr, SRG_IDX_DATA) |
             hit(addr, SRG_IDX_IRQ_STAT) |
             hit(addr, SRG_IDX_IRQ_MASK);
  endfunction

  // ***********************************************
  // bus phases
  // ***********************************************
  logic setup;
  logic acc;
  logic wr;
  logic rd;
  logic [7:0] wb;

  assign setup = PSEL & ~PENABLE;
  // ready is registered high in every access cycle: zero wait states
  assign acc = PSEL & PENABLE & r_q.ready;
  assign wr = acc & PWRITE;
  assign rd = acc & ~PWRITE;
  assign wb = PWDATA[7:0];

  // ***********************************************
  // read data, captured in setup
  // ***********************************************
  logic [7:0] rmux;

  always_comb begin
    rmux = 8'h00;
    if (hit(PADDR, SRG_IDX_CTRL)) begin
      rmux[SRG_CTRL_MIRQ_BIT] = r_q.mirq_en;
      rmux[SRG_CTRL_MST_BIT] = r_q.mst_en;
    end
    if (hit(PADDR, SRG_IDX_RATE)) begin
      // bit 7 stays zero
      rmux[SRG_RATE_PRE_LSB +: 3] = r_q.pre_sel;
      rmux[SRG_RATE_DIV_LSB +: 4] = r_q.div_sel;
    end
    if (hit(PADDR, SRG_IDX_STAT)) begin
      // bits 5:0 read zero here, low four unimplemented
      rmux[SRG_STAT_RXF_BIT] = r_q.rx_full;
      rmux[SRG_STAT_MATCH_BIT] = r_q.match;
    end
    if (hit(PADDR, SRG_IDX_MATCH)) begin
      rmux = r_q.match_val;
    end
    if (hit(PADDR, SRG_IDX_DATA)) begin
      rmux = r_q.rx_buf;
    end
    if (hit(PADDR, SRG_IDX_IRQ_STAT)) begin
      rmux[1:0] = r_q.ev_stat;
    end
    if (hit(PADDR, SRG_IDX_IRQ_MASK)) begin
      rmux[1:0] = r_q.ev_mask;
    end
  end

  // ***********************************************
  // access strobes
  // ***********************************************
  logic wr_ctrl;
  logic wr_rate;
  logic wr_stat;
  logic wr_match;
  logic wr_istat;
  logic wr_imask;
  logic rd_stat;
  logic rd_data;

  assign wr_ctrl = wr & hit(PADDR, SRG_IDX_CTRL);
  assign wr_rate = wr & hit(PADDR, SRG_IDX_RATE);
  assign wr_stat = wr & hit(PADDR, SRG_IDX_STAT);
  assign wr_match = wr & hit(PADDR, SRG_IDX_MATCH);
  assign wr_istat = wr & hit(PADDR, SRG_IDX_IRQ_STAT);
  assign wr_imask = wr & hit(PADDR, SRG_IDX_IRQ_MASK);
  assign rd_stat = rd & hit(PADDR, SRG_IDX_STAT);
  assign rd_data = rd & hit(PADDR, SRG_IDX_DATA);

  // ***********************************************
  // events
  // ***********************************************
  logic ev_rxf;
  logic ev_match;
  logic [1:0] ev_new;

  assign ev_rxf = XFER_DONE;
  // compare one cycle after the buffer loads, so full is already seen
  assign ev_match = r_q.chk & (r_q.rx_buf == r_q.match_val);
  always_comb begin
    ev_new = 2'b00;
    ev_new[SRG_EV_RXF] = ev_rxf;
    ev_new[SRG_EV_MATCH] = ev_match;
  end

  // ***********************************************
  // next state
  // ***********************************************
  always_comb begin
    r_d = r_q;

    // bus handshake, answer ready in the first access cycle
    r_d.ready = setup;
    r_d.slverr = setup & ~mapped(PADDR);
    if (setup) begin
      r_d.rdata = PWRITE ? 8'h00 : rmux;
    end

    // configuration writes, no transfer-state interlock
    if (wr_rate) begin
      r_d.pre_sel = wb[SRG_RATE_PRE_LSB +: 3];
      r_d.div_sel = wb[SRG_RATE_DIV_LSB +: 4];
    end
    if (wr_ctrl) begin
      r_d.mirq_en = wb[SRG_CTRL_MIRQ_BIT];
      r_d.mst_en = wb[SRG_CTRL_MST_BIT];
    end
    if (wr_match) begin
      r_d.match_val = wb;
    end
    if (wr_imask) begin
      r_d.ev_mask = wb[1:0];
    end

    // receive buffer load
    r_d.chk = XFER_DONE;
    if (XFER_DONE) begin
      r_d.rx_buf = RX_DATA;
    end

    // arming by a status read that saw the flag
    if (rd_stat && r_q.rdata[SRG_STAT_RXF_BIT]) begin
      r_d.rx_arm = 1'b1;
    end
    if (rd_stat && r_q.rdata[SRG_STAT_MATCH_BIT]) begin
      r_d.match_arm = 1'b1;
    end

    // receive full: cleared by armed data read, set wins
    if (rd_data && r_q.rx_arm) begin
      r_d.rx_full = 1'b0;
      r_d.rx_arm = 1'b0;
    end
    if (ev_rxf) begin
      r_d.rx_full = 1'b1;
      r_d.rx_arm = 1'b0;
    end

    // match: only armed write of one touches status
    if (wr_stat && r_q.match_arm && wb[SRG_STAT_MATCH_BIT]) begin
      r_d.match = 1'b0;
      r_d.match_arm = 1'b0;
    end
    if (ev_match) begin
      r_d.match = 1'b1;
      r_d.match_arm = 1'b0;
    end

    // sticky events, write one to clear, new event wins
    if (wr_istat) begin
      r_d.ev_stat = r_q.ev_stat & ~wb[1:0];
    end
    r_d.ev_stat = r_d.ev_stat | ev_new;

    // one level request line
    r_d.irq = (|(r_d.ev_stat & r_d.ev_mask)) |
              (r_d.match & r_d.mirq_en);
  end

  // ***********************************************
  // registers
  // ***********************************************
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      r_q <= '0;
      r_q.pre_sel <= SRG_PRE_RST;
      r_q.div_sel <= SRG_DIV_RST;
      r_q.match_val <= SRG_BYTE_RST;
      r_q.rx_buf <= SRG_BYTE_RST;
      r_q.ev_stat <= SRG_EV_RST;
      r_q.ev_mask <= SRG_EV_RST;
    end else begin
      r_q <= r_d;
    end
  end

  // ***********************************************
  // rate generator
  // ***********************************************
  // clock runs only as master and only while a transfer is active
  assign rif.run = r_q.mst_en & XFER_ACTIVE;
  assign rif.pre_sel = r_q.pre_sel;
  assign rif.div_sel = r_q.div_sel;

  srg_rate_gen u_gen (
    .CLK_SYS(CLK_SYS),
    .RSTN(RSTN),
    .rif(rif.gen)
  );

  // ***********************************************
  // outputs
  // ***********************************************
  assign PRDATA = {24'h000000, r_q.rdata};
  assign PREADY = r_q.ready;
  assign PSLVERR = r_q.slverr;
  assign SCK = rif.sck;
  assign SCK_EDGE = rif.edge_p;
  assign IRQ = r_q.irq;

endmodule // srg_top
`default_nettype wire

// ### pkg/srg_pkg.sv
/*
  srg_pkg: register map, field positions, reset values and state
  layouts for the serial rate generator and receive status block.
  assumes: 32-bit APB with word-aligned registers, 8-bit data in bits 7:0.
*/
`default_nettype none
package srg_pkg;
  // ***********************************************
  // register indices (byte address = index * 4)
  // ***********************************************
  localparam logic [7:0] SRG_IDX_CTRL = 8'h01;
  localparam logic [7:0] SRG_IDX_RATE = 8'h02;
  localparam logic [7:0] SRG_IDX_STAT = 8'h03;
  localparam logic [7:0] SRG_IDX_MATCH = 8'h04;
  localparam logic [7:0] SRG_IDX_DATA = 8'h05;
  localparam logic [7:0] SRG_IDX_IRQ_STAT = 8'h08;
  localparam logic [7:0] SRG_IDX_IRQ_MASK = 8'h09;
  localparam int SRG_ADDR_W = 8;
  // ***********************************************
  // field positions
  // ***********************************************
  localparam int SRG_RATE_PRE_LSB = 4;
  localparam int SRG_RATE_DIV_LSB = 0;
  localparam int SRG_CTRL_MIRQ_BIT = 7;
  localparam int SRG_CTRL_MST_BIT = 0;
  localparam int SRG_STAT_RXF_BIT = 7;
  localparam int SRG_STAT_MATCH_BIT = 6;
  localparam int SRG_EV_RXF = 1;
  localparam int SRG_EV_MATCH = 0;
  // ***********************************************
  // limits and reset values
  // ***********************************************
  localparam logic [3:0] SRG_DIV_SEL_MAX = 4'h8;
  localparam logic [2:0] SRG_PRE_RST = 3'h0;
  localparam logic [3:0] SRG_DIV_RST = 4'h0;
  localparam logic [7:0] SRG_BYTE_RST = 8'h00;
  localparam logic [1:0] SRG_EV_RST = 2'h0;
  // ***********************************************
  // state layouts
  // ***********************************************
  typedef struct packed {
    logic [2:0] pre_sel;
    logic [3:0] div_sel;
    logic mirq_en;
    logic mst_en;
    logic [7:0] match_val;
    logic [7:0] rx_buf;
    logic rx_full;
    logic match;
    logic rx_arm;
    logic match_arm;
    logic chk;
    logic [1:0] ev_stat;
    logic [1:0] ev_mask;
    logic irq;
    logic [7:0] rdata;
    logic ready;
    logic slverr;
  } srg_regs_t;
  typedef struct packed {
    logic [2:0] pre_cnt;
    logic [7:0] div_cnt;
    logic sck;
    logic edge_p;
  } srg_gen_t;
endpackage
`default_nettype wire

// ### pkg/srg_rate_if.sv
/*
  srg_rate_if: carries rate selection from the register file to the
  rate generator and the serial clock back.
  assumes: both ends run on the same system clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface srg_rate_if;
  logic run;
  logic [2:0] pre_sel;
  logic [3:0] div_sel;
  logic sck;
  logic edge_p;
  modport gen (input run, input pre_sel, input div_sel, output sck, output edge_p);
  modport ctl (output run, output pre_sel, output div_sel, input sck, input edge_p);
endinterface
`default_nettype wire

// ### rtl/srg_rate_gen.sv
/*
  srg_rate_gen: prescaler then power-of-two divider, toggles the serial
  clock each half bit period.
  assumes: selections are stable while run is high; run low parks it.
*/
`timescale 1ns/1ps
`default_nettype none
module srg_rate_gen
  import srg_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RSTN,
  // rate link
  srg_rate_if.gen rif
);
  srg_gen_t s_q;
  srg_gen_t s_d;
  logic [3:0] code;
  logic [7:0] half_last;

  // reserved divider codes run at the slowest legal rate
  assign code = (rif.div_sel > SRG_DIV_SEL_MAX) ? SRG_DIV_SEL_MAX : rif.div_sel;
  // half period is 2^code prescaled ticks, full bit is 2^(code+1)
  assign half_last = 8'((9'h001 << code) - 9'h001);

  always_comb begin
    s_d = s_q;
    s_d.edge_p = 1'b0;
    if (!rif.run) begin
      s_d.pre_cnt = 3'h0;
      s_d.div_cnt = 8'h00;
      s_d.sck = 1'b0;
    end else if (s_q.pre_cnt == rif.pre_sel) begin
      // prescaler ratio is select plus one
      s_d.pre_cnt = 3'h0;
      if (s_q.div_cnt == half_last) begin
        // bit rate = clock / (prescale * divide)
        s_d.div_cnt = 8'h00;
        s_d.sck = ~s_q.sck;
        s_d.edge_p = 1'b1;
      end else begin
        s_d.div_cnt = s_q.div_cnt + 8'h01;
      end
    end else begin
      s_d.pre_cnt = s_q.pre_cnt + 3'h1;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rif.sck = s_q.sck;
  assign rif.edge_p = s_q.edge_p;
endmodule // srg_rate_gen
`default_nettype wire

// ### tb/srg_top_asserts.sv
/* srg_top_chk: port-level assertions for srg_top, bound below.
   assumes: one clock, rate and control shadowed from APB writes. */
`timescale 1ns/1ps
`default_nettype none
module srg_top_chk
  import srg_pkg::*;
(
  // clock and apb
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [SRG_ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  // shift side and outputs
  input wire logic XFER_ACTIVE,
  input wire logic XFER_DONE,
  input wire logic [7:0] RX_DATA,
  input wire logic SCK,
  input wire logic SCK_EDGE,
  input wire logic IRQ
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  logic [7:0] rate_q, ctl_q, mat_q, msk_q, rx_q;
  logic [12:0] gap_q;
  logic seen_q;
  logic wr;
  logic [12:0] per;
  assign wr = PSEL && PENABLE && PREADY && PWRITE;
  // reserved divisor codes run as the slowest one
  assign per = ({10'h0, rate_q[6:4]} + 13'h1) << ((rate_q[3:0] > 4'h8) ? 4'h8 : rate_q[3:0]);
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      {rate_q, ctl_q, mat_q, msk_q, rx_q, gap_q, seen_q} <= '0;
    end else begin
      if (wr && PADDR == 8'h08) rate_q <= PWDATA[7:0];
      if (wr && PADDR == 8'h04) ctl_q <= PWDATA[7:0];
      if (wr && PADDR == 8'h10) mat_q <= PWDATA[7:0];
      if (wr && PADDR == 8'h24) msk_q <= PWDATA[7:0];
      if (XFER_DONE) rx_q <= RX_DATA;
      gap_q <= SCK_EDGE ? 13'h1 : gap_q + 13'h1;
      seen_q <= XFER_ACTIVE && (seen_q || SCK_EDGE);
    end
  end
  // **********
  // properties
  // **********
  property p_rdy; PSEL && !PENABLE |=> PENABLE && PREADY; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready in access cycle");
  property p_br7; PREADY && !PWRITE && PADDR == 8'h08 |-> !PRDATA[7]; endproperty
  a_br7: assert property (p_br7) else $error("rate top bit not zero");
  property p_stlo; PREADY && !PWRITE && PADDR == 8'h0c |-> PRDATA[3:0] == 4'h0; endproperty
  a_stlo: assert property (p_stlo) else $error("status low bits not zero");
  property p_per; SCK_EDGE && seen_q |-> gap_q == per; endproperty
  a_per: assert property (p_per) else $error("serial clock period wrong");
  property p_idle; (!XFER_ACTIVE) [*3] |-> !SCK && !SCK_EDGE; endproperty
  a_idle: assert property (p_idle) else $error("serial clock moves while idle");
  property p_dat; PREADY && !PWRITE && PADDR == 8'h14 |-> PRDATA == {24'h0, rx_q}; endproperty
  a_dat: assert property (p_dat) else $error("data register not last byte");
  property p_mirq; XFER_DONE && RX_DATA == mat_q && ctl_q[7] |-> ##[1:3] IRQ; endproperty
  a_mirq: assert property (p_mirq) else $error("match interrupt missing");
  property p_quiet; (msk_q == 8'h00 && !ctl_q[7]) [*2] |-> !IRQ; endproperty
  a_quiet: assert property (p_quiet) else $error("interrupt with all sources off");
  c_per: cover property (SCK_EDGE && seen_q);
  c_irq: cover property (IRQ);
  c_done: cover property (XFER_DONE && RX_DATA == mat_q);
endmodule // srg_top_chk
bind srg_top srg_top_chk u_chk (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .XFER_ACTIVE(XFER_ACTIVE),
  .XFER_DONE(XFER_DONE), .RX_DATA(RX_DATA), .SCK(SCK), .SCK_EDGE(SCK_EDGE), .IRQ(IRQ));
`default_nettype wire

// ### tb/srg_peer.sv
/* srg_peer: shift-side stand-in, one byte per sixteen serial edges.
   assumes: same clock as the block; byte held outside the done pulse is inverted. */
`timescale 1ns/1ps
`default_nettype none
module srg_peer (
  // clock
  input wire logic clk,
  input wire logic rstn,
  // control
  input wire logic start,
  input wire logic [7:0] byte_in,
  input wire logic sck_edge,
  // shift side
  output logic active,
  output logic done,
  output logic [7:0] rx
);
  logic [7:0] hold_q;
  logic [4:0] cnt_q;
  // never shows valid data outside the pulse
  assign rx = done ? hold_q : ~hold_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {active, done, hold_q, cnt_q} <= '0;
    end else begin
      done <= 1'b0;
      if (start && !active) begin
        active <= 1'b1;
        cnt_q <= 5'h0;
        hold_q <= byte_in;
      end else if (active && sck_edge) begin
        cnt_q <= cnt_q + 5'h1;
        if (cnt_q == 5'hf) begin
          active <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule // srg_peer
`default_nettype wire

// ### tb/test_spi_rate_gen_and_status.sv
/* test_spi_rate_gen_and_status: register, rate and flag checks of srg_top.
   assumes: srg_peer stands in for the shift logic. */
`timescale 1ns/1ps
`default_nettype none
module test_spi_rate_gen_and_status
  import srg_pkg::*;
;
  logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, start = 0;
  logic [7:0] paddr = 8'h00, tx_b = 8'h00, rxd;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, act, done, sck, sedge, irq;
  logic [40:0] expq[$];
  int fail_count = 0, comparisons = 0;
  initial begin
    forever #12.5 clk = ~clk;
  end
  srg_top uut (.CLK_SYS(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .XFER_ACTIVE(act),
    .XFER_DONE(done), .RX_DATA(rxd), .SCK(sck), .SCK_EDGE(sedge), .IRQ(irq));
  srg_peer u_peer (.clk(clk), .rstn(rstn), .start(start), .byte_in(tx_b), .sck_edge(sedge),
    .active(act), .done(done), .rx(rxd));
  // **********
  // tasks
  // **********
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", nm, e, g);
      fail_count++;
    end
  endtask
  task give_verdict;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= idx << 2;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      give_verdict;
    end
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task rd(input logic [7:0] idx, input logic [7:0] e);
    // unmapped word offsets must answer with an error flag
    expq.push_back({!(idx inside {SRG_IDX_CTRL, SRG_IDX_RATE, SRG_IDX_STAT, SRG_IDX_MATCH, SRG_IDX_DATA,
      SRG_IDX_IRQ_STAT, SRG_IDX_IRQ_MASK}), idx, 24'h0, e});
    apb(1'b0, idx, 32'h0);
  endtask
  task wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, {24'h0, d});
  endtask
  // read data taken only at the completing edge
  always @(posedge clk) begin
    if (psel && pen && pready === 1'b1 && !pwr && expq.size() > 0) begin
      chk($sformatf("reg %h", expq[0][39:32]), expq[0][31:0], prdata);
      chk($sformatf("slverr %h", expq[0][39:32]), {31'h0, expq[0][40]}, {31'h0, pslverr});
      void'(expq.pop_front());
    end
  end
  // **********
  // sequence
  // **********
  initial begin
    logic [7:0] b;
    int n;
    void'($urandom(60));
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rd(SRG_IDX_RATE, 8'h00);
    wr(SRG_IDX_RATE, 8'hff);
    rd(SRG_IDX_RATE, 8'h7f);
    wr(SRG_IDX_STAT, 8'hff);
    rd(SRG_IDX_STAT, 8'h00);
    rd(8'h0f, 8'h00);
    wr(SRG_IDX_MATCH, 8'h5a);
    wr(SRG_IDX_CTRL, 8'h81);
    for (int i = 0; i < 10; i++) begin
      b = i[0] ? 8'h5a : 8'($urandom);
      wr(SRG_IDX_RATE, {1'b0, 3'(i), 4'(i)});
      rd(SRG_IDX_RATE, {1'b0, 3'(i), 4'(i)});
      @(posedge clk);
      start <= 1'b1;
      tx_b <= b;
      @(posedge clk);
      start <= 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 40000) begin
        @(posedge clk);
        n++;
      end
      if (n >= 40000) begin
        fail_count++;
        give_verdict;
      end
      repeat (4) @(posedge clk);
      chk("irq", {31'h0, b == 8'h5a}, {31'h0, irq});
      rd(SRG_IDX_DATA, b);
      wr(SRG_IDX_STAT, 8'hff);
      rd(SRG_IDX_STAT, {1'b1, b == 8'h5a, 6'h0});
      rd(SRG_IDX_DATA, b);
      rd(SRG_IDX_STAT, {1'b0, b == 8'h5a, 6'h0});
      wr(SRG_IDX_STAT, 8'h40);
      rd(SRG_IDX_STAT, 8'h00);
      chk("irq", 32'h0, {31'h0, irq});
    end
    // transfer running with master off: serial clock must stay parked
    wr(SRG_IDX_CTRL, 8'h00);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    n = 0;
    repeat (40) begin
      @(posedge clk);
      if (sck !== 1'b0 || sedge !== 1'b0) begin
        n++;
      end
    end
    chk("sck_not_master", 32'h0, n);
    rd(SRG_IDX_RATE, 8'h19);
    rd(SRG_IDX_IRQ_STAT, 8'h03);
    wr(SRG_IDX_CTRL, 8'h01);
    wr(SRG_IDX_IRQ_MASK, 8'h02);
    repeat (2) @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    wr(SRG_IDX_IRQ_STAT, 8'h02);
    repeat (2) @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    rd(SRG_IDX_IRQ_STAT, 8'h01);
    give_verdict;
  end
endmodule // test_spi_rate_gen_and_status
`default_nettype wire
